// File: rtl/uwa_top.sv
// Wake-up event logic, device address holding and AHB-Lite registers
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
module uwa_top #(
    parameter int NAK_CYCLES = uwa_pkg::SETUP_NAK_CYC
) (
    input  wire logic                        core_clk,
    input  wire logic                        rst_n,
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic                             hreadyout,
    output logic [31:0]                      hrdata,
    output logic                             hresp,
    input  wire logic                        usb_dp,
    input  wire logic                        usb_dm,
    input  wire logic                        disk_interface_irq,
    input  wire logic                        gpio_irq_line,
    input  wire logic                        core_clk_stopped,
    input  wire logic                        sie_addr_load,
    input  wire logic [uwa_pkg::ADDR_W-1:0]  sie_addr,
    input  wire logic                        sie_high_speed,
    input  wire logic                        tok_valid,
    input  wire logic [uwa_pkg::ADDR_W-1:0]  tok_addr,
    output logic                             wake_irq_input,
    output logic                             core_restart,
    output logic                             ring_osc_restart,
    output logic                             xtal_osc_restart,
    output logic                             xcvr_power_down,
    output logic                             remote_wake_signal_bit,
    output logic                             phy_disconnect,
    output logic                             addr_match,
    output logic                             setup_nak_window,
    output logic                             irq
);
    typedef struct packed {
        logic [4:0]                 wsrc_rsv;
        logic                       f_busrst;
        logic                       f_resume;
        logic                       f_ext;
        logic [2:0]                 wmask;
        logic [uwa_pkg::ADDR_W-1:0] dev_addr;
        logic                       cfg_disc;
        logic                       cfg_rsv3;
        logic                       cfg_rwake;
        logic                       cfg_susp;
        logic                       addr_en;
        logic [uwa_pkg::IRQ_N-1:0]  irq_sts;
        logic [uwa_pkg::IRQ_N-1:0]  irq_msk;
        logic                       wr_pend;
        logic                       rd_pend;
        logic [7:0]                 a_idx;
        logic                       hready;
        logic [31:0]                hrdata;
        logic                       wake;
        logic                       core_rst;
        logic                       osc_rst;
        logic                       irq;
        logic                       match;
    } uwa_top_st_t;

    uwa_top_st_t st_r;
    uwa_top_st_t st_nxt;

    uwa_evt_if evt ();

    // Sticky flag update: a set in the clearing cycle keeps the flag
    function automatic logic w1c(input logic cur, input logic set, input logic clr);
        w1c = set | (cur & ~clr);
    endfunction

    // Line monitor owns pin sampling and the timed bus events
    uwa_line_mon #(
        .NAK_CYCLES (NAK_CYCLES),
        .SE0_CYCLES (uwa_pkg::SE0_CYC)
    ) u_mon (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .usb_dp   (usb_dp),
        .usb_dm   (usb_dm),
        .evt      (evt.mon)
    );

    // Resume detection is armed only while suspended
    assign evt.suspend = st_r.cfg_susp;

    // Address decode and write qualification
    logic       addr_ok;
    logic       take;
    logic [7:0] idx;
    logic       wr_now;
    logic       wr_wsrc;
    logic       wr_wmask;
    logic       wr_cfg;
    logic       wr_ctrl;
    logic       wr_ists;
    logic       wr_imsk;
    logic [7:0] wd;
    logic [2:0] wake_en;

    always_comb begin
        idx      = haddr[uwa_pkg::IDX_MSB:uwa_pkg::IDX_LSB];
        addr_ok  = (haddr[31:uwa_pkg::IDX_MSB+1] == '0)
                   && (haddr[uwa_pkg::IDX_LSB-1:0] == '0);
        take     = hsel && hready && (htrans == uwa_pkg::HTRANS_NONSEQ);
        wr_now   = st_r.wr_pend;
        wd       = hwdata[7:0];
        wr_wsrc  = wr_now && (st_r.a_idx == uwa_pkg::IDX_WAKE_SRC);
        wr_wmask = wr_now && (st_r.a_idx == uwa_pkg::IDX_WAKE_MASK);
        wr_cfg   = wr_now && (st_r.a_idx == uwa_pkg::IDX_ENG_CFG);
        wr_ctrl  = wr_now && (st_r.a_idx == uwa_pkg::IDX_CTRL);
        wr_ists  = wr_now && (st_r.a_idx == uwa_pkg::IDX_IRQ_STS);
        wr_imsk  = wr_now && (st_r.a_idx == uwa_pkg::IDX_IRQ_MSK);
        // Mask bit low means the event may wake the core
        wake_en  = {st_r.f_busrst, st_r.f_resume, st_r.f_ext} & ~st_r.wmask;
    end

    // Whole next-state computation
    always_comb begin
        st_nxt = st_r;

        // Bus-reset and resume wake flags, write one to clear
        st_nxt.f_busrst = w1c(st_r.f_busrst, evt.bus_reset_pulse,
                              wr_wsrc && wd[uwa_pkg::WK_BUSRST]);
        st_nxt.f_resume = w1c(st_r.f_resume, evt.resume_pulse,
                              wr_wsrc && wd[uwa_pkg::WK_RESUME]);
        if (wr_wsrc) begin
            st_nxt.wsrc_rsv = wd[uwa_pkg::WK_RSV_MSB:uwa_pkg::WK_RSV_LSB];
        end

        // External event follows its sources; not writable
        st_nxt.f_ext = disk_interface_irq | gpio_irq_line;

        // Only the three event mask bits are stored
        if (wr_wmask) begin
            st_nxt.wmask = wd[uwa_pkg::WK_BUSRST:uwa_pkg::WK_EXT];
        end

        // Device address: bus reset beats a load in the same cycle
        if (evt.bus_reset_pulse) begin
            st_nxt.dev_addr = '0;
        end else if (sie_addr_load) begin
            st_nxt.dev_addr = sie_addr;
        end

        // Engine configuration; resume bit is not self-clearing
        if (wr_cfg) begin
            st_nxt.cfg_susp  = wd[uwa_pkg::CFG_SUSPEND];
            st_nxt.cfg_rwake = wd[uwa_pkg::CFG_RWAKE];
            st_nxt.cfg_rsv3  = wd[uwa_pkg::CFG_RSV3];
            st_nxt.cfg_disc  = wd[uwa_pkg::CFG_DISC];
        end

        if (wr_ctrl) begin
            st_nxt.addr_en = wd[uwa_pkg::CTRL_ADDR_EN];
        end

        // Interrupt status, sticky until a one is written
        st_nxt.irq_sts[uwa_pkg::IRQ_BUSRST] = w1c(st_r.irq_sts[uwa_pkg::IRQ_BUSRST],
            evt.bus_reset_pulse, wr_ists && wd[uwa_pkg::IRQ_BUSRST]);
        st_nxt.irq_sts[uwa_pkg::IRQ_RESUME] = w1c(st_r.irq_sts[uwa_pkg::IRQ_RESUME],
            evt.resume_pulse, wr_ists && wd[uwa_pkg::IRQ_RESUME]);
        st_nxt.irq_sts[uwa_pkg::IRQ_ADDRLD] = w1c(st_r.irq_sts[uwa_pkg::IRQ_ADDRLD],
            sie_addr_load, wr_ists && wd[uwa_pkg::IRQ_ADDRLD]);
        if (wr_imsk) begin
            st_nxt.irq_msk = wd[uwa_pkg::IRQ_N-1:0];
        end
        st_nxt.irq = |(st_r.irq_sts & st_r.irq_msk);

        // Wake path: core interrupt input and clock restart requests
        st_nxt.wake     = |wake_en;
        st_nxt.core_rst = (|wake_en) & core_clk_stopped;
        st_nxt.osc_rst  = (|wake_en) & core_clk_stopped;

        // Token address compare, only with the address enabled
        st_nxt.match = tok_valid && st_r.addr_en
                       && (tok_addr == st_r.dev_addr);

        // AHB data phase of the previous transfer ends here
        st_nxt.wr_pend = 1'b0;
        if (st_r.rd_pend) begin
            // One wait state so a write just before is already visible
            st_nxt.rd_pend = 1'b0;
            st_nxt.hready  = 1'b1;
            st_nxt.hrdata  = '0;
            unique case (st_r.a_idx)
                uwa_pkg::IDX_WAKE_SRC: begin
                    st_nxt.hrdata[7:0] = {st_r.wsrc_rsv, st_r.f_busrst,
                                          st_r.f_resume, st_r.f_ext};
                end
                uwa_pkg::IDX_WAKE_MASK: begin
                    st_nxt.hrdata[7:0] = {5'h_1f, st_r.wmask};
                end
                uwa_pkg::IDX_DEV_ADDR: begin
                    st_nxt.hrdata[7:0] = {1'b1, st_r.dev_addr};
                end
                uwa_pkg::IDX_ENG_CFG: begin
                    st_nxt.hrdata[uwa_pkg::CFG_TOP]     = 1'b0;
                    st_nxt.hrdata[uwa_pkg::CFG_DISC]    = st_r.cfg_disc;
                    st_nxt.hrdata[uwa_pkg::CFG_RSV3]    = st_r.cfg_rsv3;
                    st_nxt.hrdata[uwa_pkg::CFG_SPEED]   = sie_high_speed;
                    st_nxt.hrdata[uwa_pkg::CFG_RWAKE]   = st_r.cfg_rwake;
                    st_nxt.hrdata[uwa_pkg::CFG_SUSPEND] = st_r.cfg_susp;
                end
                uwa_pkg::IDX_CTRL: begin
                    st_nxt.hrdata[uwa_pkg::CTRL_ADDR_EN] = st_r.addr_en;
                end
                uwa_pkg::IDX_IRQ_STS: begin
                    st_nxt.hrdata[uwa_pkg::IRQ_N-1:0] = st_r.irq_sts;
                end
                uwa_pkg::IDX_IRQ_MSK: begin
                    st_nxt.hrdata[uwa_pkg::IRQ_N-1:0] = st_r.irq_msk;
                end
                default: begin
                    st_nxt.hrdata = '0; // Unmapped reads return zero
                end
            endcase
        end else if (take) begin
            // Unmapped addresses get an index no register answers to
            st_nxt.a_idx = addr_ok ? idx : '0;
            if (hwrite) begin
                st_nxt.wr_pend = 1'b1;
            end else begin
                st_nxt.rd_pend = 1'b1;
                st_nxt.hready  = 1'b0;
            end
        end
    end

    // State register with documented reset values
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r           <= '0;
            st_r.wsrc_rsv  <= uwa_pkg::RST_WAKE_SRC[uwa_pkg::WK_RSV_MSB:uwa_pkg::WK_RSV_LSB];
            st_r.wmask     <= uwa_pkg::RST_WAKE_MASK[uwa_pkg::WK_BUSRST:uwa_pkg::WK_EXT];
            st_r.dev_addr  <= uwa_pkg::RST_DEV_ADDR[uwa_pkg::ADDR_W-1:0];
            st_r.cfg_disc  <= uwa_pkg::RST_ENG_CFG[uwa_pkg::CFG_DISC];
            st_r.cfg_rsv3  <= uwa_pkg::RST_ENG_CFG[uwa_pkg::CFG_RSV3];
            st_r.cfg_rwake <= uwa_pkg::RST_ENG_CFG[uwa_pkg::CFG_RWAKE];
            st_r.cfg_susp  <= uwa_pkg::RST_ENG_CFG[uwa_pkg::CFG_SUSPEND];
            st_r.irq_msk   <= uwa_pkg::RST_IRQ_MSK[uwa_pkg::IRQ_N-1:0];
            st_r.hready    <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from state flops; hresp is tied to OKAY
    assign hreadyout              = st_r.hready;
    assign hrdata                 = st_r.hrdata;
    assign hresp                  = uwa_pkg::HRESP_OKAY;
    assign wake_irq_input         = st_r.wake;
    assign core_restart           = st_r.core_rst;
    assign ring_osc_restart       = st_r.osc_rst;
    assign xtal_osc_restart       = st_r.osc_rst;
    assign xcvr_power_down        = st_r.cfg_susp;
    assign remote_wake_signal_bit = st_r.cfg_rwake;
    assign phy_disconnect         = st_r.cfg_disc;
    assign addr_match             = st_r.match;
    assign setup_nak_window       = evt.setup_nak;
    assign irq                    = st_r.irq;
endmodule
`default_nettype wire

// File: rtl/uwa_pkg.sv
// Shared constants for the wake-up and bus address logic
package uwa_pkg;
    // Printed register indices; the byte address is four times the index
    localparam logic [7:0] IDX_WAKE_SRC   = 8'h_a0;
    localparam logic [7:0] IDX_WAKE_MASK  = 8'h_a6;
    localparam logic [7:0] IDX_DEV_ADDR   = 8'h_a9;
    localparam logic [7:0] IDX_ENG_CFG    = 8'h_aa;
    localparam logic [7:0] IDX_CTRL       = 8'h_b0;
    localparam logic [7:0] IDX_IRQ_STS    = 8'h_b1;
    localparam logic [7:0] IDX_IRQ_MSK    = 8'h_b2;

    // Address decode: word index bits of the byte address
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 9;

    // Wake source / mask bit positions
    localparam int WK_EXT    = 0;
    localparam int WK_RESUME = 1;
    localparam int WK_BUSRST = 2;
    localparam int WK_RSV_LSB = 3;
    localparam int WK_RSV_MSB = 7;

    // Engine configuration bit positions
    localparam int CFG_SUSPEND = 0;
    localparam int CFG_RWAKE   = 1;
    localparam int CFG_SPEED   = 2;
    localparam int CFG_RSV3    = 3;
    localparam int CFG_DISC    = 6;
    localparam int CFG_TOP     = 7;

    // Device address register
    localparam int ADDR_W   = 7;
    localparam int ADDR_TOP = 7;

    // Control register and interrupt status bits
    localparam int CTRL_ADDR_EN = 0;
    localparam int IRQ_BUSRST   = 0;
    localparam int IRQ_RESUME   = 1;
    localparam int IRQ_ADDRLD   = 2;
    localparam int IRQ_N        = 3;

    // Reset values
    localparam logic [7:0] RST_WAKE_SRC  = 8'h_00;
    localparam logic [7:0] RST_WAKE_MASK = 8'h_ff;
    localparam logic [7:0] RST_DEV_ADDR  = 8'h_00;
    localparam logic [7:0] RST_ENG_CFG   = 8'h_40;
    localparam logic [7:0] RST_IRQ_MSK   = 8'h_00;

    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h_2;
    localparam logic       HRESP_OKAY    = 1'b0;

    // Line states (dp, dm)
    localparam logic [1:0] LINE_SE0 = 2'h_0;
    localparam logic [1:0] LINE_J   = 2'h_2;

    // Timing
    localparam int CLK_NS        = 10;
    localparam int SE0_MIN_NS    = 2500;
    localparam int SE0_CYC       = (SE0_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_NAK_MS  = 10;
    localparam int SETUP_NAK_CYC = (SETUP_NAK_MS * 1000000) / CLK_NS;
endpackage

// File: rtl/uwa_evt_if.sv
// Line events passed from the line monitor to the register block
`timescale 1ns/1ps
`default_nettype none
interface uwa_evt_if;
    logic suspend;
    logic bus_reset_pulse;
    logic resume_pulse;
    logic se0_active;
    logic setup_nak;

    modport mon (
        input  suspend,
        output bus_reset_pulse,
        output resume_pulse,
        output se0_active,
        output setup_nak
    );
    modport regs (
        output suspend,
        input  bus_reset_pulse,
        input  resume_pulse,
        input  se0_active,
        input  setup_nak
    );
endinterface
`default_nettype wire

// File: rtl/uwa_line_mon.sv
// Bus line monitor: pin synchroniser, bus reset and resume detection
`timescale 1ns/1ps
`default_nettype none
module uwa_line_mon #(
    parameter int NAK_CYCLES = uwa_pkg::SETUP_NAK_CYC,
    parameter int SE0_CYCLES = uwa_pkg::SE0_CYC
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic usb_dp,
    input  wire logic usb_dm,
    uwa_evt_if.mon    evt
);
    localparam int SW = $clog2(SE0_CYCLES + 1);
    localparam int NW = $clog2(NAK_CYCLES + 1);

    typedef struct packed {
        logic [1:0]    sync1;
        logic [1:0]    sync2;
        logic [1:0]    prev;
        logic [SW-1:0] se0_cnt;
        logic          rst_seen;
        logic [NW-1:0] nak_cnt;
        logic          rst_p;
        logic          res_p;
        logic          nak;
    } uwa_mon_st_t;

    uwa_mon_st_t st_r;
    uwa_mon_st_t st_nxt;

    // Line sampling, SE0 timing and the NAK window
    always_comb begin
        st_nxt         = st_r;
        st_nxt.sync1   = {usb_dp, usb_dm};
        st_nxt.sync2   = st_r.sync1;
        st_nxt.prev    = st_r.sync2;
        st_nxt.rst_p   = 1'b0;
        st_nxt.res_p   = 1'b0;
        if (st_r.sync2 == uwa_pkg::LINE_SE0) begin
            // Counter saturates so long resets report only once
            if (st_r.se0_cnt != SW'(SE0_CYCLES)) begin
                st_nxt.se0_cnt = st_r.se0_cnt + SW'(1);
            end
            if (st_r.se0_cnt == SW'(SE0_CYCLES - 1)) begin
                st_nxt.rst_p    = 1'b1;
                st_nxt.rst_seen = 1'b1;
            end
        end else begin
            st_nxt.se0_cnt = '0;
            // Release of a bus reset opens the SETUP NAK window
            if (st_r.rst_seen) begin
                st_nxt.rst_seen = 1'b0;
                st_nxt.nak_cnt  = NW'(NAK_CYCLES);
            end else if (st_r.nak_cnt != '0) begin
                st_nxt.nak_cnt = st_r.nak_cnt - NW'(1);
            end
        end
        st_nxt.nak = (st_nxt.nak_cnt != '0);
        // Departure from J while suspended is a global resume
        if (evt.suspend && st_r.prev == uwa_pkg::LINE_J
            && st_r.sync2 != uwa_pkg::LINE_J) begin
            st_nxt.res_p = 1'b1;
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Start at the idle J level so reset gives no false SE0 or edge
            st_r       <= '0;
            st_r.sync1 <= uwa_pkg::LINE_J;
            st_r.sync2 <= uwa_pkg::LINE_J;
            st_r.prev  <= uwa_pkg::LINE_J;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign evt.bus_reset_pulse = st_r.rst_p;
    assign evt.resume_pulse    = st_r.res_p;
    assign evt.se0_active      = st_r.rst_seen;
    assign evt.setup_nak       = st_r.nak;
endmodule
`default_nettype wire

// File: dv/uwa_host_model.sv
// Bus host model that drives the two data lines
`timescale 1ns/1ps
`default_nettype none
module uwa_host_model (
    input  wire logic core_clk,
    output logic      usb_dp,
    output logic      usb_dm
);
    // Idle bus rests in J, where the pull-up leaves it
    initial begin
        usb_dp = 1'b1;
        usb_dm = 1'b0;
    end

    // Hold one line state for n cycles, then return to J
    task automatic drive(input logic [1:0] st, input int n);
        @(posedge core_clk);
        {usb_dp, usb_dm} <= st;
        repeat (n) @(posedge core_clk);
        {usb_dp, usb_dm} <= uwa_pkg::LINE_J;
    endtask
endmodule
`default_nettype wire

// File: dv/uwa_top_assertions.sv
// Port-level checker for the wake-up and address logic
`timescale 1ns/1ps
`default_nettype none
module uwa_chk #(
    parameter int NAK_CYCLES = 20
) (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        core_clk_stopped,
    input wire logic        tok_valid,
    input wire logic        core_restart,
    input wire logic        ring_osc_restart,
    input wire logic        xtal_osc_restart,
    input wire logic        addr_match,
    input wire logic        setup_nak_window
);
    logic [31:0] nak_cnt_r;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Length of the current NAK window, so long windows need no repetition
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            nak_cnt_r <= 32'h_0000_0000;
        end else begin
            nak_cnt_r <= setup_nak_window ? nak_cnt_r + 32'h_0000_0001 : 32'h_0000_0000;
        end
    end

    property p_rd_wait;
        hsel && hready && htrans == 2'h_2 && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read data phase not one wait");
    property p_wr_fast;
        hsel && hready && htrans == 2'h_2 && hwrite |=> hreadyout;
    endproperty
    a_wr_fast: assert property (p_wr_fast) else $error("write data phase stalled");
    property p_rd_upper;
        hrdata[31:8] == 24'h_00_0000;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
    property p_match;
        addr_match |-> $past(tok_valid);
    endproperty
    a_match: assert property (p_match) else $error("match without token");
    property p_restart;
        core_restart |-> $past(core_clk_stopped);
    endproperty
    a_restart: assert property (p_restart) else $error("restart while core runs");
    property p_ring;
        ring_osc_restart == core_restart;
    endproperty
    a_ring: assert property (p_ring) else $error("ring restart differs");
    property p_xtal;
        xtal_osc_restart == core_restart;
    endproperty
    a_xtal: assert property (p_xtal) else $error("crystal restart differs");
    property p_nak_len;
        nak_cnt_r <= NAK_CYCLES;
    endproperty
    a_nak_len: assert property (p_nak_len) else $error("NAK window too long");
    property p_nak_end;
        $fell(setup_nak_window) |-> nak_cnt_r == NAK_CYCLES;
    endproperty
    a_nak_end: assert property (p_nak_end) else $error("NAK window length wrong");
endmodule
`default_nettype wire

// File: dv/tb.sv
// Self-checking testbench for the wake-up and address logic
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int NAK = 20;
    localparam int LIMIT = 20000;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h_0000_0000;
    logic [1:0]  htrans = 2'h_0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h_2;
    logic [31:0] hwdata = 32'h_0000_0000;
    logic        disk_interface_irq = 1'b0;
    logic        gpio_irq_line = 1'b0;
    logic        core_clk_stopped = 1'b0;
    logic        sie_addr_load = 1'b0;
    logic [6:0]  sie_addr = 7'h_00;
    logic        sie_high_speed = 1'b0;
    logic        tok_valid = 1'b0;
    logic [6:0]  tok_addr = 7'h_00;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, usb_dp, usb_dm, wake_irq_input, core_restart;
    logic        ring_osc_restart, xtal_osc_restart, xcvr_power_down, remote_wake_signal_bit;
    logic        phy_disconnect, addr_match, setup_nak_window, irq;
    int          fail_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    logic [31:0] q;

    uwa_top #(.NAK_CYCLES(NAK)) i_dut (
        .core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .usb_dp, .usb_dm,
        .disk_interface_irq, .gpio_irq_line, .core_clk_stopped, .sie_addr_load,
        .sie_addr, .sie_high_speed, .tok_valid, .tok_addr, .wake_irq_input,
        .core_restart, .ring_osc_restart, .xtal_osc_restart, .xcvr_power_down,
        .remote_wake_signal_bit, .phy_disconnect, .addr_match, .setup_nak_window, .irq
    );
    uwa_host_model i_host (.core_clk, .usb_dp, .usb_dm);

    // Free-running 100 MHz clock
    always #5 core_clk = ~core_clk;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Hang guard: a stuck handshake ends as a failure
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fail_count++;
            end_of_test();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk1(input string n, input logic e, input logic g);
        chk(n, {31'h_0, e}, {31'h_0, g});
    endtask

    // One AHB single transfer; waits on hready, never on a fixed count
    task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {22'h_0, idx, 2'h_0};
        htrans <= uwa_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h_0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, {24'h_0, d});
    endtask

    task automatic rc(input logic [7:0] idx, input logic [7:0] e, input string n);
        bus(idx, 1'b0, 32'h_0000_0000);
        chk(n, {24'h_0, e}, q);
    endtask

    // Flags pass through a few register stages
    task automatic settle();
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    task automatic tok(input logic [6:0] a, input logic e);
        @(posedge core_clk);
        tok_valid <= 1'b1;
        tok_addr <= a;
        @(posedge core_clk);
        tok_valid <= 1'b0;
        #1;
        chk1("addr_match", e, addr_match);
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        rc(uwa_pkg::IDX_WAKE_SRC, 8'h_00, "src reset");
        chk1("phy_disconnect", 1'b1, phy_disconnect);
        rc(uwa_pkg::IDX_WAKE_MASK, 8'h_ff, "mask reset");
        rc(uwa_pkg::IDX_DEV_ADDR, 8'h_80, "addr reset");
        rc(uwa_pkg::IDX_ENG_CFG, 8'h_40, "cfg reset");
        wr(uwa_pkg::IDX_WAKE_MASK, 8'h_00);
        rc(uwa_pkg::IDX_WAKE_MASK, 8'h_f8, "mask ro");
        wr(uwa_pkg::IDX_DEV_ADDR, 8'h_7f);
        rc(uwa_pkg::IDX_DEV_ADDR, 8'h_80, "addr ro");
        sie_high_speed <= 1'b1;
        wr(uwa_pkg::IDX_ENG_CFG, 8'h_c3);
        rc(uwa_pkg::IDX_ENG_CFG, 8'h_47, "cfg rw");
        chk1("xcvr_power_down", 1'b1, xcvr_power_down);
        chk1("remote_wake", 1'b1, remote_wake_signal_bit);
        wr(uwa_pkg::IDX_ENG_CFG, 8'h_41);
        gpio_irq_line <= 1'b1;
        core_clk_stopped <= 1'b1;
        rc(uwa_pkg::IDX_WAKE_SRC, 8'h_01, "ext gpio");
        settle();
        chk1("wake", 1'b1, wake_irq_input);
        chk1("core_restart", 1'b1, core_restart);
        chk1("ring_restart", 1'b1, ring_osc_restart);
        chk1("xtal_restart", 1'b1, xtal_osc_restart);
        wr(uwa_pkg::IDX_WAKE_MASK, 8'h_01);
        settle();
        chk1("wake masked", 1'b0, wake_irq_input);
        chk1("restart masked", 1'b0, core_restart);
        @(posedge core_clk);
        gpio_irq_line <= 1'b0;
        disk_interface_irq <= 1'b1;
        rc(uwa_pkg::IDX_WAKE_SRC, 8'h_01, "ext disk");
        disk_interface_irq <= 1'b0;
        rc(uwa_pkg::IDX_WAKE_SRC, 8'h_00, "ext idle");
        i_host.drive(2'h_1, 4);
        rc(uwa_pkg::IDX_WAKE_SRC, 8'h_02, "resume");
        settle();
        chk1("wake resume", 1'b1, wake_irq_input);
        wr(uwa_pkg::IDX_WAKE_SRC, 8'h_f8);
        rc(uwa_pkg::IDX_WAKE_SRC, 8'h_fa, "write zero");
        wr(uwa_pkg::IDX_WAKE_SRC, 8'h_02);
        rc(uwa_pkg::IDX_WAKE_SRC, 8'h_00, "resume w1c");
        wr(uwa_pkg::IDX_ENG_CFG, 8'h_40);
        i_host.drive(2'h_1, 4);
        rc(uwa_pkg::IDX_WAKE_SRC, 8'h_00, "resume unsuspended");
        @(posedge core_clk);
        sie_addr_load <= 1'b1;
        sie_addr <= 7'h_35;
        @(posedge core_clk);
        sie_addr_load <= 1'b0;
        rc(uwa_pkg::IDX_DEV_ADDR, 8'h_b5, "addr load");
        tok(7'h_35, 1'b0);
        wr(uwa_pkg::IDX_CTRL, 8'h_01);
        tok(7'h_35, 1'b1);
        tok(7'h_36, 1'b0);
        wr(uwa_pkg::IDX_IRQ_STS, 8'h_07);
        i_host.drive(uwa_pkg::LINE_SE0, 200);
        rc(uwa_pkg::IDX_WAKE_SRC, 8'h_00, "short se0");
        i_host.drive(uwa_pkg::LINE_SE0, 260);
        for (int i = 0; i < 10 && setup_nak_window !== 1'b1; i++) @(posedge core_clk);
        chk1("nak window", 1'b1, setup_nak_window);
        rc(uwa_pkg::IDX_WAKE_SRC, 8'h_04, "bus reset");
        rc(uwa_pkg::IDX_DEV_ADDR, 8'h_80, "addr cleared");
        rc(uwa_pkg::IDX_IRQ_STS, 8'h_01, "irq status");
        chk1("irq masked", 1'b0, irq);
        wr(uwa_pkg::IDX_IRQ_MSK, 8'h_01);
        settle();
        chk1("irq raised", 1'b1, irq);
        wr(uwa_pkg::IDX_IRQ_STS, 8'h_01);
        settle();
        chk1("irq cleared", 1'b0, irq);
        wr(uwa_pkg::IDX_WAKE_SRC, 8'h_04);
        rc(uwa_pkg::IDX_WAKE_SRC, 8'h_00, "reset w1c");
        chk1("nak over", 1'b0, setup_nak_window);
        wr(8'h_bf, 8'h_ff);
        rc(8'h_bf, 8'h_00, "unmapped");
        chk1("hresp", uwa_pkg::HRESP_OKAY, hresp);
        end_of_test();
    end
endmodule

bind uwa_top uwa_chk #(.NAK_CYCLES(NAK_CYCLES)) i_chk (
    .core_clk, .rst_n, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hrdata,
    .core_clk_stopped, .tok_valid, .core_restart, .ring_osc_restart,
    .xtal_osc_restart, .addr_match, .setup_nak_window
);
`default_nettype wire
